// ### common/npec_map.vh
// Purpose: Constants of the flash program/erase control block
// Assumes: Included by the design file only
// Notes: Offsets are register indices, byte address is four times
`ifndef NPEC_MAP_VH
`define NPEC_MAP_VH
`define NPEC_IX_ADDR 12'h81a
`define NPEC_IX_DATA 12'h81c
`define NPEC_IX_CTL 12'h81e
`define NPEC_IX_KEY 12'h81f
`define NPEC_B_RD 0
`define NPEC_B_WR 1
`define NPEC_B_EN 2
`define NPEC_B_ERR 3
`define NPEC_B_ERASE 4
`define NPEC_B_LATCH 5
`define NPEC_B_REGION 6
`define NPEC_KEY_FIRST 8'h55
`define NPEC_KEY_SECOND 8'haa
`define NPEC_LATCH_FILL 14'h3fff
`define NPEC_ROW_LAST 5'h1f
`define NPEC_ST_IDLE 3'h0
`define NPEC_ST_READ 3'h1
`define NPEC_ST_ERASE 3'h2
`define NPEC_ST_PROG 3'h3
`define NPEC_ST_LATCH 3'h4
`define NPEC_OP_READ 2'h0
`define NPEC_OP_ERASE 2'h1
`define NPEC_OP_PROG 2'h2
`define NPEC_K_IDLE 2'h0
`define NPEC_K_ONE 2'h1
`define NPEC_K_TWO 2'h2
`define NPEC_UID_LO 15'h0000
`define NPEC_UID_HI 15'h0003
`define NPEC_CFG_LO 15'h0005
`define NPEC_CFG_HI 15'h000b
`define NPEC_DEV_HI 15'h0006
`define NPEC_DIA_LO 15'h0100
`define NPEC_DIA_HI 15'h02ff
`define NPEC_RESP_OK 2'h0
`define NPEC_RESP_ERR 2'h2
`endif

// ### logic/npec_top.v
// Purpose: Flash program/erase control registers and sequencer
// Assumes: Flash side answers each request with a one-cycle ack
// Notes: Data word and reset-abort shadow are not reset
`timescale 1ns/10ps
`include "npec_map.vh"

// Behaviour
// - Data word 14 bits, byte lanes separate
// - Region select picks info space or flash
// - Latch-only trigger loads row latch only
// - Latch-only clear programs row; erase ignores it
// - Erase clears whole 32-word row to ones
// - Program without erase when erase clear
// - Fault on reset abort, broken unlock, protection
// - Hardware never clears fault flag
// - Software may write fault flag to one
// - Program enable low inhibits program/erase
// - Write trigger starts op, zero means idle
// - Ops self-timed, trigger clears when done
// - Writing zero to busy trigger ignored
// - Keys 0x55 then 0xAA before trigger
// - Read trigger loads data, self-clears
// - Read trigger only set by software
// - Unlock key 8-bit write-only, resets zero
// - Fault flag undefined while trigger set
// - Data word unknown at power-on, kept on reset
// - Cell address 15 bits, two byte lanes
// - Invalid info-space read returns zeros
// - Latches return to 0x3fff after program
module npec_top (
  input wire CLK_SYS_I,
  input wire RESET_N_I,
  input wire [13:0] S_AXI_AWADDR_I,
  input wire S_AXI_AWVALID_I,
  output reg S_AXI_AWREADY_O,
  input wire [31:0] S_AXI_WDATA_I,
  input wire [3:0] S_AXI_WSTRB_I,
  input wire S_AXI_WVALID_I,
  output reg S_AXI_WREADY_O,
  output reg [1:0] S_AXI_BRESP_O,
  output reg S_AXI_BVALID_O,
  input wire S_AXI_BREADY_I,
  input wire [13:0] S_AXI_ARADDR_I,
  input wire S_AXI_ARVALID_I,
  output reg S_AXI_ARREADY_O,
  output reg [31:0] S_AXI_RDATA_O,
  output reg [1:0] S_AXI_RRESP_O,
  output reg S_AXI_RVALID_O,
  input wire S_AXI_RREADY_I,
  output reg FL_REQ_O,
  output reg [1:0] FL_OP_O,
  output reg FL_REGION_O,
  output reg [14:0] FL_ADDR_O,
  output reg [13:0] FL_WDATA_O,
  input wire FL_ACK_I,
  input wire [13:0] FL_RDATA_I,
  input wire FL_WPROT_I
);

  reg [14:0] cell_address;
  reg [13:0] data_word;
  reg region_select;
  reg latch_only;
  reg erase_sel;
  reg fault_flag;
  reg program_enable;
  reg wr_trig;
  reg rd_trig;
  reg [7:0] unlock_key;
  reg [1:0] key_st;
  reg [2:0] st;
  reg [4:0] word_ix;
  reg [13:0] row_latch [0:31];
  reg busy_shadow;
  reg first_cycle;
  wire wr_go;
  wire rd_go;
  wire [11:0] wix;
  wire [11:0] rix;
  wire [7:0] wb0;
  wire [7:0] wb1;
  wire hit_ctl;
  wire hit_key;
  wire bad_w;
  wire wr_req;
  wire unlocked;
  wire info_rd_ok;
  wire info_wr_ok;
  wire prot;
  wire abort;
  wire row_done;
  reg [15:0] rd_val;
  genvar g;

  assign wr_go = S_AXI_AWVALID_I & S_AXI_WVALID_I & ~S_AXI_AWREADY_O &
                 ~S_AXI_BVALID_O;
  assign rd_go = S_AXI_ARVALID_I & ~S_AXI_ARREADY_O & ~S_AXI_RVALID_O;
  assign wix = S_AXI_AWADDR_I[13:2];
  assign rix = S_AXI_ARADDR_I[13:2];
  assign wb0 = S_AXI_WDATA_I[7:0];
  assign wb1 = S_AXI_WDATA_I[15:8];
  assign hit_ctl = wr_go & (wix == `NPEC_IX_CTL) & S_AXI_WSTRB_I[0];
  assign hit_key = wr_go & (wix == `NPEC_IX_KEY) & S_AXI_WSTRB_I[0];
  assign bad_w = (wix != `NPEC_IX_ADDR) & (wix != `NPEC_IX_DATA) &
                 (wix != `NPEC_IX_CTL) & (wix != `NPEC_IX_KEY);
  // Trigger request only counts when idle
  assign wr_req = hit_ctl & wb0[`NPEC_B_WR] & ~wr_trig & ~rd_trig;
  assign unlocked = (key_st == `NPEC_K_TWO);
  // Information space: which cells answer reads and accept writes
  assign info_rd_ok =
    (cell_address <= `NPEC_UID_HI) |
    ((cell_address >= `NPEC_CFG_LO) & (cell_address <= `NPEC_CFG_HI)) |
    ((cell_address >= `NPEC_DIA_LO) & (cell_address <= `NPEC_DIA_HI));
  assign info_wr_ok = (cell_address <= `NPEC_UID_HI) |
    ((cell_address > `NPEC_DEV_HI) & (cell_address <= `NPEC_CFG_HI));
  // Region from this same write, not the stale one; latch loads skip it
  assign prot = (FL_WPROT_I | (wb0[`NPEC_B_REGION] & ~info_wr_ok)) &
                (wb0[`NPEC_B_ERASE] | ~wb0[`NPEC_B_LATCH]);
  // Any write other than the next unlock step breaks the sequence
  assign abort = wr_go & (
    ((key_st == `NPEC_K_ONE) &
     ~(hit_key & (wb0 == `NPEC_KEY_SECOND))) |
    (unlocked & ~hit_ctl));
  assign row_done = (st == `NPEC_ST_PROG) & FL_ACK_I &
                    (word_ix == `NPEC_ROW_LAST);

  // Bus write channel: address and data taken together
  always @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O <= 1'b0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= `NPEC_RESP_OK;
    end else begin
      S_AXI_AWREADY_O <= wr_go;
      S_AXI_WREADY_O <= wr_go;
      if (wr_go) begin
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= bad_w ? `NPEC_RESP_ERR : `NPEC_RESP_OK;
      end else if (S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // Read mux; key register reads as zero since it is write-only
  always @* begin
    rd_val = 16'h0000;
    if (rix == `NPEC_IX_ADDR) begin
      rd_val = {1'b0, cell_address};
    end else if (rix == `NPEC_IX_DATA) begin
      rd_val = {2'b00, data_word};
    end else if (rix == `NPEC_IX_CTL) begin
      rd_val = {9'h000, region_select, latch_only, erase_sel,
                fault_flag, program_enable, wr_trig, rd_trig};
    end
  end

  always @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h00000000;
      S_AXI_RRESP_O <= `NPEC_RESP_OK;
    end else begin
      S_AXI_ARREADY_O <= rd_go;
      if (rd_go) begin
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RDATA_O <= {16'h0000, rd_val};
        if ((rix == `NPEC_IX_ADDR) | (rix == `NPEC_IX_DATA) |
            (rix == `NPEC_IX_CTL) | (rix == `NPEC_IX_KEY)) begin
          S_AXI_RRESP_O <= `NPEC_RESP_OK;
        end else begin
          S_AXI_RRESP_O <= `NPEC_RESP_ERR;
        end
      end else if (S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end

  // Cell address, both byte lanes
  always @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cell_address <= 15'h0000;
    end else if (wr_go & (wix == `NPEC_IX_ADDR)) begin
      if (S_AXI_WSTRB_I[0]) begin
        cell_address[7:0] <= wb0;
      end
      if (S_AXI_WSTRB_I[1]) begin
        cell_address[14:8] <= wb1[6:0];
      end
    end
  end

  // Data word has no reset so it survives every reset
  always @(posedge CLK_SYS_I) begin
    if ((st == `NPEC_ST_READ) & FL_ACK_I) begin
      if (region_select & ~info_rd_ok) begin
        data_word <= 14'h0000;
      end else begin
        data_word <= FL_RDATA_I;
      end
    end else if (wr_go & (wix == `NPEC_IX_DATA)) begin
      if (S_AXI_WSTRB_I[0]) begin
        data_word[7:0] <= wb0;
      end
      if (S_AXI_WSTRB_I[1]) begin
        data_word[13:8] <= wb1[5:0];
      end
    end
  end

  // Unlock key and its sequence tracker
  always @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      unlock_key <= 8'h00;
      key_st <= `NPEC_K_IDLE;
    end else begin
      if (hit_key) begin
        unlock_key <= wb0;
      end
      if (hit_key & (wb0 == `NPEC_KEY_FIRST)) begin
        key_st <= `NPEC_K_ONE;
      end else if (hit_key & (wb0 == `NPEC_KEY_SECOND) &
                   (key_st == `NPEC_K_ONE)) begin
        key_st <= `NPEC_K_TWO;
      end else if (wr_go) begin
        key_st <= `NPEC_K_IDLE;
      end
    end
  end

  // Control bits
  always @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      region_select <= 1'b0;
      latch_only <= 1'b0;
      erase_sel <= 1'b0;
      program_enable <= 1'b0;
      rd_trig <= 1'b0;
    end else begin
      if (hit_ctl) begin
        region_select <= wb0[`NPEC_B_REGION];
        latch_only <= wb0[`NPEC_B_LATCH];
        erase_sel <= wb0[`NPEC_B_ERASE];
        program_enable <= wb0[`NPEC_B_EN];
      end
      if ((st == `NPEC_ST_READ) & FL_ACK_I) begin
        rd_trig <= 1'b0;
      end else if (hit_ctl & wb0[`NPEC_B_RD] & ~wr_trig) begin
        rd_trig <= 1'b1;
      end
    end
  end

  // Write trigger: accepted only right after the unlock keys
  always @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      wr_trig <= 1'b0;
    end else if (wr_trig) begin
      if (((st == `NPEC_ST_ERASE) & FL_ACK_I) | row_done |
          (st == `NPEC_ST_LATCH)) begin
        wr_trig <= 1'b0;
      end
    end else if (wr_req & unlocked & wb0[`NPEC_B_EN] & ~prot) begin
      wr_trig <= 1'b1;
    end
  end

  // Fault flag: hardware sets win over software writes
  always @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      fault_flag <= 1'b0;
      first_cycle <= 1'b1;
    end else begin
      first_cycle <= 1'b0;
      if ((first_cycle & busy_shadow) | abort |
          (wr_req & unlocked & wb0[`NPEC_B_EN] & prot)) begin
        fault_flag <= 1'b1;
      end else if (hit_ctl) begin
        fault_flag <= wb0[`NPEC_B_ERR];
      end
    end
  end

  // Remembers a busy trigger across reset; power-on value unknown
  always @(posedge CLK_SYS_I) begin
    if (RESET_N_I & ~first_cycle) begin
      busy_shadow <= wr_trig;
    end else if (RESET_N_I) begin
      busy_shadow <= 1'b0;
    end
  end

  // Row write latches, one per word of the row
  generate
    for (g = 0; g < 32; g = g + 1) begin : latch_g
      always @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
          row_latch[g] <= `NPEC_LATCH_FILL;
        end else if (row_done) begin
          row_latch[g] <= `NPEC_LATCH_FILL;
        end else if ((st == `NPEC_ST_LATCH) &
                     (cell_address[4:0] == g)) begin
          row_latch[g] <= data_word;
        end
      end
    end
  endgenerate

  // Sequencer: one flash request at a time, each waits for ack
  always @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st <= `NPEC_ST_IDLE;
      word_ix <= 5'h00;
      FL_REQ_O <= 1'b0;
      FL_OP_O <= `NPEC_OP_READ;
      FL_REGION_O <= 1'b0;
      FL_ADDR_O <= 15'h0000;
      FL_WDATA_O <= 14'h0000;
    end else begin
      case (st)
        `NPEC_ST_IDLE: begin
          word_ix <= 5'h00;
          FL_REGION_O <= region_select;
          if (wr_trig & erase_sel) begin
            st <= `NPEC_ST_ERASE;
            FL_REQ_O <= 1'b1;
            FL_OP_O <= `NPEC_OP_ERASE;
            FL_ADDR_O <= {cell_address[14:5], 5'h00};
          end else if (wr_trig & latch_only) begin
            st <= `NPEC_ST_LATCH;
          end else if (wr_trig) begin
            st <= `NPEC_ST_PROG;
            FL_REQ_O <= 1'b1;
            FL_OP_O <= `NPEC_OP_PROG;
            FL_ADDR_O <= {cell_address[14:5], 5'h00};
            FL_WDATA_O <= row_latch[0];
          end else if (rd_trig) begin
            st <= `NPEC_ST_READ;
            FL_REQ_O <= 1'b1;
            FL_OP_O <= `NPEC_OP_READ;
            FL_ADDR_O <= cell_address;
          end
        end
        `NPEC_ST_PROG: begin
          if (FL_ACK_I & (word_ix == `NPEC_ROW_LAST)) begin
            st <= `NPEC_ST_IDLE;
            FL_REQ_O <= 1'b0;
          end else if (FL_ACK_I) begin
            word_ix <= word_ix + 5'h01;
            FL_ADDR_O <= {cell_address[14:5], word_ix + 5'h01};
            FL_WDATA_O <= row_latch[word_ix + 5'h01];
          end
        end
        `NPEC_ST_ERASE, `NPEC_ST_READ: begin
          if (FL_ACK_I) begin
            st <= `NPEC_ST_IDLE;
            FL_REQ_O <= 1'b0;
          end
        end
        default: begin
          st <= `NPEC_ST_IDLE;
          FL_REQ_O <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ### test/npec_checker.sv
// Purpose: Port assertions for the flash control block
// Assumes: One clock, reset asynchronous and active low
// Notes: Values are judged by the bench, timing is judged here
`timescale 1ns/10ps
module npec_checker (
  input wire CLK_SYS_I,
  input wire RESET_N_I,
  input wire S_AXI_AWVALID_I,
  input wire S_AXI_WVALID_I,
  input wire S_AXI_AWREADY_O,
  input wire S_AXI_BVALID_O,
  input wire S_AXI_ARVALID_I,
  input wire S_AXI_ARREADY_O,
  input wire S_AXI_RVALID_O,
  input wire FL_REQ_O,
  input wire [1:0] FL_OP_O,
  input wire [14:0] FL_ADDR_O,
  input wire FL_ACK_I
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  // Only a program walk keeps the request up after an answer
  wire last_word;
  assign last_word = FL_OP_O != 2'h2 || FL_ADDR_O[4:0] == 5'h1f;
  chk_wr_answer: assert property (
    S_AXI_AWVALID_I && S_AXI_WVALID_I && !S_AXI_BVALID_O &&
    !S_AXI_AWREADY_O |=> S_AXI_AWREADY_O && S_AXI_BVALID_O)
    else $error("write not answered");
  chk_rd_answer: assert property (
    S_AXI_ARVALID_I && !S_AXI_ARREADY_O && !S_AXI_RVALID_O |=>
    S_AXI_ARREADY_O && S_AXI_RVALID_O) else $error("read not answered");
  chk_req_hold: assert property (
    FL_REQ_O && !FL_ACK_I |=> FL_REQ_O) else $error("request dropped");
  chk_req_stable: assert property (
    FL_REQ_O && !FL_ACK_I |=> $stable(FL_OP_O) && $stable(FL_ADDR_O))
    else $error("request moved");
  chk_erase_row: assert property (
    FL_REQ_O && FL_OP_O == 2'h1 |-> FL_ADDR_O[4:0] == 5'h00)
    else $error("erase not row based");
  chk_prog_start: assert property (
    $rose(FL_REQ_O) && FL_OP_O == 2'h2 |-> FL_ADDR_O[4:0] == 5'h00)
    else $error("program not at word 0");
  chk_prog_step: assert property (
    FL_REQ_O && FL_ACK_I && !last_word |=> FL_REQ_O &&
    FL_ADDR_O == $past(FL_ADDR_O) + 15'h1) else $error("bad program step");
  chk_req_done: assert property (
    FL_REQ_O && FL_ACK_I && last_word |=> !FL_REQ_O)
    else $error("request kept");
endmodule
bind npec_top npec_checker i_npec_checker (.CLK_SYS_I, .RESET_N_I,
  .S_AXI_AWVALID_I, .S_AXI_WVALID_I, .S_AXI_AWREADY_O, .S_AXI_BVALID_O,
  .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RVALID_O, .FL_REQ_O,
  .FL_OP_O, .FL_ADDR_O, .FL_ACK_I);

// ### test/npec_flash_model.sv
// Purpose: Flash array model behind the sequencer
// Assumes: One request at a time, held until answered
// Notes: Cells start at a pattern so reads can be predicted
`timescale 1ns/10ps
module npec_flash_model (
  input wire clk_i,
  input wire reset_n_i,
  input wire req_i,
  input wire [1:0] op_i,
  input wire region_i,
  input wire [14:0] addr_i,
  input wire [13:0] wdata_i,
  input wire slow_i,
  output reg ack_o,
  output reg [13:0] rdata_o
);
  reg [13:0] mem [0:65535];
  reg [5:0] cnt;
  integer i;
  initial begin
    ack_o = 1'b0;
    rdata_o = 14'h0000;
    for (i = 0; i < 65536; i = i + 1) mem[i] = i[15:2];
  end
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_o <= 1'b0;
      cnt <= 6'h00;
    end else begin
      ack_o <= 1'b0;
      // Read data is stale outside an answer, so it toggles
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) begin
        cnt <= cnt + 6'h01;
        if (cnt >= (slow_i ? 6'h28 : 6'h01)) begin
          ack_o <= 1'b1;
          cnt <= 6'h00;
          if (op_i == 2'h0) rdata_o <= mem[{region_i, addr_i}];
          if (op_i == 2'h2) mem[{region_i, addr_i}] <= wdata_i;
          if (op_i == 2'h1) for (i = 0; i < 32; i = i + 1)
            mem[{region_i, addr_i[14:5], i[4:0]}] <= 14'h3fff;
        end
      end
    end
  end
endmodule

// ### test/tb_npec_top.sv
// Purpose: Self-checking bench for the flash control block
// Assumes: Flash model answers after a short or a long wait
// Notes: Rows and data come from a fixed xorshift seed
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb_npec_top;
  localparam A = 12'h81a, D = 12'h81c, C = 12'h81e, K = 12'h81f;
  reg clk = 1'b0, rst_n = 1'b0, slow = 1'b0, wprot = 1'b0;
  reg awv = 1'b0, wv = 1'b0, arv = 1'b0;
  reg [13:0] awa = 14'h0, ara = 14'h0;
  reg [31:0] wd = 32'h0, seed = 32'h1972, v;
  reg [1:0] rsp;
  reg [14:0] row;
  reg [13:0] w [0:3];
  int failures = 0, comparisons = 0, t = 0, i;
  wire awr, wrd, bv, arr, rv, req, rgn, ack;
  wire [1:0] br, rr, op;
  wire [31:0] rdat;
  wire [14:0] fa;
  wire [13:0] fw, frd;
  npec_top i_npec_top (.CLK_SYS_I(clk), .RESET_N_I(rst_n),
    .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'h3), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(1'b1), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr),
    .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(1'b1), .FL_REQ_O(req),
    .FL_OP_O(op), .FL_REGION_O(rgn), .FL_ADDR_O(fa), .FL_WDATA_O(fw),
    .FL_ACK_I(ack), .FL_RDATA_I(frd), .FL_WPROT_I(wprot));
  npec_flash_model i_npec_flash_model (.clk_i(clk), .reset_n_i(rst_n),
    .req_i(req), .op_i(op), .region_i(rgn), .addr_i(fa), .wdata_i(fw),
    .slow_i(slow), .ack_o(ack), .rdata_o(frd));
  function [31:0] rnd;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction
  task wr(input [11:0] ix, input [15:0] d);
    reg done;
    begin
      done = 1'b0;
      awa <= {ix, 2'b00};
      wd <= {16'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      while (awv || wv || !done) begin
        @(posedge clk);
        if (awr) awv <= 1'b0;
        if (wrd) wv <= 1'b0;
        if (bv) begin
          done = 1'b1;
          rsp = br;
        end
      end
    end
  endtask
  task rd(input [11:0] ix);
    reg done;
    begin
      done = 1'b0;
      ara <= {ix, 2'b00};
      arv <= 1'b1;
      while (arv || !done) begin
        @(posedge clk);
        if (arr) arv <= 1'b0;
        if (rv) begin
          done = 1'b1;
          v = rdat;
          rsp = rr;
        end
      end
    end
  endtask
  task idle;
    begin
      v = 32'h2;
      while (v[1:0] !== 2'b00) rd(C);
    end
  endtask
  task go(input [7:0] b);
    begin
      wr(K, 16'h55);
      wr(K, 16'haa);
      wr(C, {8'h0, b});
    end
  endtask
  task rdw(input r, input [14:0] a);
    begin
      wr(A, {1'b0, a});
      wr(C, {8'h0, 1'b0, r, 6'h01});
      idle;
      rd(D);
    end
  endtask
  task rst;
    begin
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
    end
  endtask
  task endt;
    begin
      t++;
      $display("test %0d ends, failures %0d", t, failures);
    end
  endtask
  task finish_test;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    forever #20 clk = ~clk;
  end
  // Long enough for every walk of a slow flash, short enough to stop
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(C);
    `CHK(v, 32'h0)
    rd(K);
    `CHK(v, 32'h0)
    rd(12'h800);
    `CHK(rsp, 2'h2)
    wr(12'h800, 16'h0);
    `CHK(rsp, 2'h2)
    v = rnd();
    wr(D, v[15:0]);
    rst;
    rd(D);
    `CHK(v[15:0], {2'h0, wd[13:0]})
    v = rnd();
    wr(A, v[15:0]);
    rd(A);
    `CHK(v[15:0], {1'b0, wd[14:0]})
    for (i = 0; i < 2; i++) begin
      rdw(i[0], 15'h0100);
      `CHK(v[13:0], {i[0], 13'h0040})
    end
    rdw(1'b1, 15'h0004);
    `CHK(v[13:0], 14'h0)
    endt;
    v = rnd();
    row = {v[14:5], 5'h00};
    wr(A, {1'b0, row} | 16'h3);
    go(8'h16);
    idle;
    rdw(1'b0, row + 15'h1f);
    `CHK(v[13:0], 14'h3fff)
    for (i = 0; i < 4; i++) begin
      v = rnd();
      w[i] = v[13:0];
      wr(A, {1'b0, row} + i[15:0]);
      wr(D, {2'h0, w[i]});
      go(8'h26);
      idle;
    end
    rdw(1'b0, row + 15'h1);
    `CHK(v[13:0], 14'h3fff)
    wr(A, {1'b0, row});
    wr(D, {2'h0, w[0]});
    go(8'h06);
    idle;
    for (i = 0; i < 4; i++) begin
      rdw(1'b0, row + i[14:0]);
      `CHK(v[13:0], w[i])
    end
    wr(A, {1'b0, row});
    go(8'h12);
    idle;
    rdw(1'b0, row);
    `CHK(v[13:0], w[0])
    go(8'h06);
    idle;
    rdw(1'b0, row + 15'h2);
    `CHK(v[13:0], 14'h3fff)
    endt;
    slow <= 1'b1;
    go(8'h16);
    wr(C, 16'h0004);
    rd(C);
    `CHK(v[1], 1'b1)
    idle;
    go(8'h16);
    rst;
    rd(C);
    `CHK(v[3:1], 3'b100)
    wr(D, 16'h0);
    rd(C);
    `CHK(v[3], 1'b1)
    wr(C, 16'h0);
    rd(C);
    `CHK(v[7:0], 8'h00)
    wr(C, 16'h0008);
    rd(C);
    `CHK(v[3], 1'b1)
    wr(C, 16'h0);
    slow <= 1'b0;
    wprot <= 1'b1;
    go(8'h16);
    rd(C);
    `CHK(v[3:1], 3'b110)
    wprot <= 1'b0;
    wr(C, 16'h0);
    wr(K, 16'h55);
    wr(D, 16'h0);
    rd(C);
    `CHK(v[3], 1'b1)
    wr(C, 16'h0006);
    rd(C);
    `CHK(v[2:1], 2'b10)
    endt;
    finish_test;
  end
endmodule
